// ==== shared/dcc_defines.vh ====
// Purpose: constants for the dual comparator control block
// Assumes: classic wishbone, 32-bit data, byte addresses, one word per register
// Notes: byte addresses are multiples of four
// Function
// - comparator runs when its enable bit is 1, otherwise off
// - two-bit select routes one of four pins to the inverting input
// - reference bit picks internal reference or pin for non-inverting input
// - result readable in own control register and mirrored in second register
// - pin driven only with output enable, direction cleared and comparator on
// - output enable overrides port latch; enable bit alone has no effect
// - internal result registered every instruction cycle; pin path adds one more register
// - polarity bit 1 inverts the comparison result
// - snapshot latch captures result on every control register read
// - sample latch updates each phase one; mismatch is xor of both
// - mismatch holds until read or result returns to snapshot value
// - any write to control register also clears the mismatch
// - mismatch and flag work regardless of output enable
// - flag sets on rising edge of mismatch, not its level
// - after read-cleared mismatch, return to old value raises new interrupt
// - flag cleared only by writing 0; writing 1 sets it
// - request needs flag, comparator, peripheral and global enables
// - change coinciding with a control register read may miss the flag
// - enabled comparator stays running in sleep; clearing enable stops it
// - change wakes sleep with comparator and peripheral enables set
// - only comparator two feeds timer1 gate and synchronisation
// - reset returns all control registers to reset values, comparators off
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH
`define DCC_ADDR_CTRL1 5'h00
`define DCC_ADDR_CTRL2 5'h04
`define DCC_ADDR_CTRL2B 5'h08
`define DCC_ADDR_FLAG 5'h0c
`define DCC_ADDR_IRQEN 5'h10
`define DCC_ADDR_INTCTL 5'h14
`define DCC_FLAG_RST 2'h0
`define DCC_IRQEN_RST 2'h0
`define DCC_SYNC_RST 3'h0
`define DCC_BIT_ON 7
`define DCC_BIT_OUT 6
`define DCC_BIT_OE 5
`define DCC_BIT_POL 4
`define DCC_BIT_REF 2
`define DCC_CTRL_RST 8'h00
`define DCC_CTRL_WMASK 8'hb7
`define DCC_BIT_MOUT1 7
`define DCC_BIT_MOUT2 6
`define DCC_BIT_IRQ1 5
`define DCC_BIT_IRQ2 6
`define DCC_BIT_GIE 7
`define DCC_BIT_PERIPHERAL_IRQ_ENABLE 6
`endif

// ==== rtl/dcc_top.v ====
// Purpose: digital control and event logic around two analog comparators
// Assumes: analog result enters asynchronously; one cycle is one instruction
// Notes: registers at byte offsets 0x00 ctrl1, 0x04 ctrl2, 0x08 ctrl2b,
//        0x0c flags, 0x10 irq enables, 0x14 interrupt control
`include "dcc_defines.vh"
`default_nettype none
module dcc_top
(
    // clock, reset, enable
    input wire CLOCK_I,
    input wire RST_N_I,
    input wire CE_I,
    // wishbone slave
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [4:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    // analog front end: raw comparison, 1 when non-inverting input is higher
    input wire CMP1_RAW_I,
    input wire CMP2_RAW_I,
    output reg CMP1_ON_O,
    output reg CMP2_ON_O,
    output reg [1:0] CMP1_INV_SEL_O,
    output reg [1:0] CMP2_INV_SEL_O,
    output reg CMP1_REF_SEL_O,
    output reg CMP2_REF_SEL_O,
    // pins
    input wire PIN1_DIR_I,
    input wire PIN2_DIR_I,
    output reg PIN1_OVERRIDE_O,
    output reg PIN2_OVERRIDE_O,
    output reg PIN1_OUT_O,
    output reg PIN2_OUT_O,
    // system
    input wire SLEEP_I,
    output reg IRQ_O,
    output reg WAKE_O,
    output reg TMR1_CMP_O
);

    // register state
    reg [7:0] ctrl1;
    reg [7:0] ctrl2;
    reg [1:0] flag;
    reg [1:0] irq_en;
    reg peripheral_irq_enable;
    reg global_irq_enable;

    // input filters and event latches, one set per comparator
    reg [2:0] sync1;
    reg [2:0] sync2;
    reg raw1;
    reg raw2;
    reg [1:0] res;
    reg [1:0] snap;
    reg [1:0] sample;
    reg [1:0] mism_d;
    wire [1:0] mism;
    wire [1:0] rise;
    wire [1:0] pend;

    // bus decode
    wire acc;
    wire wr;
    wire rd1;
    wire rd2;
    wire wr_ctrl1;
    wire wr_ctrl2;
    wire wr_flag;
    wire wr_irqen;
    wire wr_intctl;
    wire [4:0] a;
    reg [31:0] next_dat;
    reg [1:0] next_flag;

    // one address match shared by the strobes and the read mux
    function hit;
        input [4:0] adr;
        input [4:0] reg_adr;
        begin
            hit = (adr == reg_adr);
        end
    endfunction

    function apply_pol;
        input r;
        input pol;
        begin
            apply_pol = r ^ pol;
        end
    endfunction

    // pin shows the result only with oe set, direction output and on set
    function pin_drive;
        input oe;
        input dir;
        input on;
        input r;
        begin
            pin_drive = oe & ~dir & on & r;
        end
    endfunction

    // one flag bit: software value on a write, but a hardware set wins
    function flag_bit;
        input cur;
        input we;
        input sw;
        input set;
        begin
            if (set)
                flag_bit = 1'b1;
            else if (we)
                flag_bit = sw;
            else
                flag_bit = cur;
        end
    endfunction

    assign a = WB_ADR_I;
    // one access per ack; the ack cycle masks a second hit
    assign acc = WB_CYC_I & WB_STB_I & ~WB_ACK_O & CE_I;
    assign wr = acc & WB_WE_I & WB_SEL_I[0];
    // a write counts as a read of the control register too
    assign rd1 = acc & hit(a, `DCC_ADDR_CTRL1);
    assign rd2 = acc & hit(a, `DCC_ADDR_CTRL2);
    assign wr_ctrl1 = wr & hit(a, `DCC_ADDR_CTRL1);
    assign wr_ctrl2 = wr & hit(a, `DCC_ADDR_CTRL2);
    assign wr_flag = wr & hit(a, `DCC_ADDR_FLAG);
    assign wr_irqen = wr & hit(a, `DCC_ADDR_IRQEN);
    assign wr_intctl = wr & hit(a, `DCC_ADDR_INTCTL);
    assign mism = snap ^ sample;
    assign rise = mism & ~mism_d;
    assign pend = flag & irq_en;

    // raw levels are asynchronous; a level counts once two stages agree
    always @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            sync1 <= `DCC_SYNC_RST;
            raw1 <= 1'b0;
        end
        else if (CE_I)
        begin
            sync1 <= {sync1[1:0], CMP1_RAW_I};
            if (sync1[2] == sync1[1])
                raw1 <= sync1[1];
        end
    end

    always @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            sync2 <= `DCC_SYNC_RST;
            raw2 <= 1'b0;
        end
        else if (CE_I)
        begin
            sync2 <= {sync2[1:0], CMP2_RAW_I};
            if (sync2[2] == sync2[1])
                raw2 <= sync2[1];
        end
    end

    // bus answer: ack stands for exactly one cycle; data reloads from the read mux every cycle
    always @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0;
        end
        else if (CE_I)
        begin
            WB_ACK_O <= acc;
            WB_DAT_O <= next_dat;
        end
    end

    always @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            ctrl1 <= `DCC_CTRL_RST;
            ctrl2 <= `DCC_CTRL_RST;
        end
        else if (CE_I)
        begin
            if (wr_ctrl1)
                ctrl1 <= WB_DAT_I[7:0] & `DCC_CTRL_WMASK;
            if (wr_ctrl2)
                ctrl2 <= WB_DAT_I[7:0] & `DCC_CTRL_WMASK;
        end
    end

    always @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            irq_en <= `DCC_IRQEN_RST;
            peripheral_irq_enable <= 1'b0;
            global_irq_enable <= 1'b0;
        end
        else if (CE_I)
        begin
            if (wr_irqen)
                irq_en <= {WB_DAT_I[`DCC_BIT_IRQ2], WB_DAT_I[`DCC_BIT_IRQ1]};
            if (wr_intctl)
            begin
                global_irq_enable <= WB_DAT_I[`DCC_BIT_GIE];
                peripheral_irq_enable <= WB_DAT_I[`DCC_BIT_PERIPHERAL_IRQ_ENABLE];
            end
        end
    end

    // comparator one event path
    always @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            res[0] <= 1'b0;
            sample[0] <= 1'b0;
            snap[0] <= 1'b0;
            mism_d[0] <= 1'b0;
        end
        else if (CE_I)
        begin
            // off comparator reads low; off is its lowest-power state
            res[0] <= ctrl1[`DCC_BIT_ON] &
                apply_pol(raw1, ctrl1[`DCC_BIT_POL]);
            sample[0] <= res[0];
            if (rd1)
                snap[0] <= res[0];
            mism_d[0] <= mism[0];
        end
    end

    // comparator two event path, independent of comparator one
    always @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            res[1] <= 1'b0;
            sample[1] <= 1'b0;
            snap[1] <= 1'b0;
            mism_d[1] <= 1'b0;
        end
        else if (CE_I)
        begin
            res[1] <= ctrl2[`DCC_BIT_ON] &
                apply_pol(raw2, ctrl2[`DCC_BIT_POL]);
            sample[1] <= res[1];
            if (rd2)
                snap[1] <= res[1];
            mism_d[1] <= mism[1];
        end
    end

    // the flag follows the edge of the mismatch, so software may clear
    // it while the mismatch level still stands
    always @*
    begin
        next_flag = flag;
        next_flag[0] = flag_bit(flag[0], wr_flag,
            WB_DAT_I[`DCC_BIT_IRQ1], rise[0]);
        next_flag[1] = flag_bit(flag[1], wr_flag,
            WB_DAT_I[`DCC_BIT_IRQ2], rise[1]);
    end

    always @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            flag <= `DCC_FLAG_RST;
        else if (CE_I)
            flag <= next_flag;
    end

    always @*
    begin
        next_dat = 32'h0;
        if (hit(a, `DCC_ADDR_CTRL1))
            next_dat[7:0] = {ctrl1[7], res[0], ctrl1[5:0]};
        else if (hit(a, `DCC_ADDR_CTRL2))
            next_dat[7:0] = {ctrl2[7], res[1], ctrl2[5:0]};
        else if (hit(a, `DCC_ADDR_CTRL2B))
        begin
            next_dat[`DCC_BIT_MOUT1] = res[0];
            next_dat[`DCC_BIT_MOUT2] = res[1];
        end
        else if (hit(a, `DCC_ADDR_FLAG))
        begin
            next_dat[`DCC_BIT_IRQ1] = flag[0];
            next_dat[`DCC_BIT_IRQ2] = flag[1];
        end
        else if (hit(a, `DCC_ADDR_IRQEN))
        begin
            next_dat[`DCC_BIT_IRQ1] = irq_en[0];
            next_dat[`DCC_BIT_IRQ2] = irq_en[1];
        end
        else if (hit(a, `DCC_ADDR_INTCTL))
        begin
            next_dat[`DCC_BIT_GIE] = global_irq_enable;
            next_dat[`DCC_BIT_PERIPHERAL_IRQ_ENABLE] = peripheral_irq_enable;
        end
    end

    // analog front-end controls
    always @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            CMP1_ON_O <= 1'b0;
            CMP2_ON_O <= 1'b0;
            CMP1_INV_SEL_O <= 2'h0;
            CMP2_INV_SEL_O <= 2'h0;
            CMP1_REF_SEL_O <= 1'b0;
            CMP2_REF_SEL_O <= 1'b0;
        end
        else if (CE_I)
        begin
            CMP1_ON_O <= ctrl1[`DCC_BIT_ON];
            CMP2_ON_O <= ctrl2[`DCC_BIT_ON];
            CMP1_INV_SEL_O <= ctrl1[1:0];
            CMP2_INV_SEL_O <= ctrl2[1:0];
            CMP1_REF_SEL_O <= ctrl1[`DCC_BIT_REF];
            CMP2_REF_SEL_O <= ctrl2[`DCC_BIT_REF];
        end
    end

    // pins
    always @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            PIN1_OVERRIDE_O <= 1'b0;
            PIN2_OVERRIDE_O <= 1'b0;
            PIN1_OUT_O <= 1'b0;
            PIN2_OUT_O <= 1'b0;
        end
        else if (CE_I)
        begin
            // port latch yields to output enable regardless of on bit
            PIN1_OVERRIDE_O <= ctrl1[`DCC_BIT_OE];
            PIN2_OVERRIDE_O <= ctrl2[`DCC_BIT_OE];
            // top outputs are flopped, so the pin lags the result by one
            PIN1_OUT_O <= pin_drive(ctrl1[`DCC_BIT_OE], PIN1_DIR_I,
                ctrl1[`DCC_BIT_ON], res[0]);
            PIN2_OUT_O <= pin_drive(ctrl2[`DCC_BIT_OE], PIN2_DIR_I,
                ctrl2[`DCC_BIT_ON], res[1]);
        end
    end

    // system requests
    always @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            IRQ_O <= 1'b0;
            WAKE_O <= 1'b0;
            TMR1_CMP_O <= 1'b0;
        end
        else if (CE_I)
        begin
            IRQ_O <= global_irq_enable & peripheral_irq_enable & |pend;
            // wake ignores the global enable; it only gates the handler
            WAKE_O <= SLEEP_I & peripheral_irq_enable & |pend;
            // comparator one has no timer link by design
            TMR1_CMP_O <= res[1];
        end
    end

endmodule
`default_nettype wire

// ==== bench/dcc_assertions.sv ====
// Purpose: port-level checks for the dual comparator control block
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to dcc_top below the module
`default_nettype none
module dcc_chk
(
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    // pins and system
    input wire logic PIN1_DIR_I,
    input wire logic PIN2_DIR_I,
    input wire logic PIN1_OUT_O,
    input wire logic PIN2_OUT_O,
    input wire logic SLEEP_I,
    input wire logic WAKE_O,
    input wire logic IRQ_O,
    input wire logic CMP1_ON_O,
    input wire logic CMP2_ON_O,
    input wire logic TMR1_CMP_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    a_ack_answers: assert property
        (WB_CYC_I && WB_STB_I && CE_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acknowledged next cycle");
    a_ack_has_cause: assert property
        ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without a request");
    a_reset_clears: assert property (disable iff (1'b0)
        !RST_N_I && CE_I |=> !WB_ACK_O && !IRQ_O && !CMP1_ON_O)
        else $error("outputs not cleared by reset");
    a_pin1_dir: assert property (PIN1_OUT_O |-> $past(!PIN1_DIR_I))
        else $error("pin one driven while direction is input");
    a_pin2_dir: assert property (PIN2_OUT_O |-> $past(!PIN2_DIR_I))
        else $error("pin two driven while direction is input");
    a_wake_needs_sleep: assert property (WAKE_O |-> $past(SLEEP_I))
        else $error("wake raised outside sleep");
    a_timer_idle: assert property (!CMP2_ON_O [*4] |-> !TMR1_CMP_O)
        else $error("timer link active with comparator off");
    c_irq: cover property (IRQ_O);
    c_wake: cover property (WAKE_O);
    c_pin: cover property (PIN1_OUT_O);
endmodule
bind dcc_top dcc_chk i_chk (.CLOCK_I, .RST_N_I, .CE_I, .WB_CYC_I,
    .WB_STB_I, .WB_ACK_O, .PIN1_DIR_I, .PIN2_DIR_I, .PIN1_OUT_O,
    .PIN2_OUT_O, .SLEEP_I, .WAKE_O, .IRQ_O, .CMP1_ON_O, .CMP2_ON_O,
    .TMR1_CMP_O);
`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: self-checking bench for the dual comparator control block
// Assumes: wishbone answers in one cycle; result settles within ten cycles
// Notes: random control words use a fixed seed
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLOCK_I = 0, RST_N_I = 0, cyc = 0, stb = 0, we = 0;
    logic [4:0] adr = 0;
    logic [31:0] dat = 0, q;
    logic raw1 = 0, raw2 = 0, dir1 = 1, dir2 = 1, sleep = 0, ce = 1;
    wire [31:0] dout;
    wire ack, p1, p2, ov1, ov2, tmr, irq, wake, on1, on2, r1, r2;
    wire [1:0] s1, s2;
    int err_count = 0, n_tests = 0, k;
    logic [7:0] d;
    always #50 CLOCK_I = ~CLOCK_I;
    dcc_top i_dut (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .CE_I(ce),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack),
        .CMP1_RAW_I(raw1), .CMP2_RAW_I(raw2), .CMP1_ON_O(on1),
        .CMP2_ON_O(on2), .CMP1_INV_SEL_O(s1), .CMP2_INV_SEL_O(s2),
        .CMP1_REF_SEL_O(r1), .CMP2_REF_SEL_O(r2), .PIN1_DIR_I(dir1),
        .PIN2_DIR_I(dir2), .PIN1_OVERRIDE_O(ov1), .PIN2_OVERRIDE_O(ov2),
        .PIN1_OUT_O(p1), .PIN2_OUT_O(p2), .SLEEP_I(sleep), .IRQ_O(irq),
        .WAKE_O(wake), .TMR1_CMP_O(tmr));
    // expected comparator result after the polarity bit
    function automatic logic exp_res(input logic r, input logic p);
        return r ^ p;
    endfunction
    task done(input string t);
        $display("test %s done", t);
    endtask
    task finish_test;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // one classic cycle; release only after the ack edge
    task wb(input logic w, input logic [4:0] a, input logic [7:0] v);
        int i;
        @(posedge CLOCK_I);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, v};
        i = 0;
        do
        begin
            @(posedge CLOCK_I);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (i >= 20)
        begin
            err_count++;
            finish_test;
        end
        q = dout;
        cyc <= 0; stb <= 0;
    endtask
    task settle;
        repeat (10) @(posedge CLOCK_I);
    endtask
    initial
    begin
        void'($urandom(32'h37b15ae7));
        repeat (8) @(posedge CLOCK_I);
        RST_N_I <= 1;
        wb(0, 5'h00, 0); `CHK("ctrl1 reset", 0, q[7:0]);
        // every select code on both comparators, random oe, pol, ref
        for (k = 0; k < 8; k++)
        begin
            d = ($urandom & 8'h34) | 8'h80 | {6'h0, k[2:1]};
            wb(1, {2'b0, k[0], 2'b0}, d);
            wb(0, {2'b0, k[0], 2'b0}, 0);
            `CHK("ctrl", d & 8'hb7, q[7:0] & 8'hbf);
            `CHK("sel", k[2:1], k[0] ? s2 : s1);
            `CHK("ref", d[2], k[0] ? r2 : r1);
            `CHK("on", 1, k[0] ? on2 : on1);
        end
        wb(1, 5'h04, 8'h00);
        dir1 <= 0;
        for (k = 0; k < 4; k++)
        begin
            raw1 <= k[0];
            wb(1, 5'h00, 8'ha0 | {3'h0, k[1], 4'h0});
            settle;
            wb(0, 5'h00, 0); `CHK("result", exp_res(k[0], k[1]), q[6]);
            wb(0, 5'h08, 0); `CHK("mirror", exp_res(k[0], k[1]), q[7]);
            `CHK("pin", exp_res(k[0], k[1]), p1);
        end
        dir1 <= 1; settle; `CHK("pin input", 0, p1);
        done("select and output");
        raw1 <= 0; wb(1, 5'h00, 8'h80); settle;
        wb(1, 5'h0c, 0); wb(0, 5'h00, 0);
        raw1 <= 1; settle;
        wb(0, 5'h0c, 0); `CHK("flag set", 8'h20, q[7:0]);
        wb(1, 5'h0c, 0); settle;
        wb(0, 5'h0c, 0); `CHK("flag edge", 0, q[7:0]);
        wb(0, 5'h00, 0); raw1 <= 0; settle;
        wb(0, 5'h0c, 0); `CHK("flag back", 8'h20, q[7:0]);
        wb(1, 5'h10, 8'h20); wb(1, 5'h14, 8'hc0); settle;
        `CHK("irq on", 1, irq);
        wb(1, 5'h14, 8'h40); settle; `CHK("irq gated", 0, irq);
        sleep <= 1; settle; `CHK("wake", 1, wake);
        sleep <= 0;
        wb(1, 5'h0c, 8'h40); wb(0, 5'h0c, 0);
        `CHK("flag sw", 8'h40, q[7:0]);
        done("flags and interrupts");
        dir2 <= 0; raw2 <= 1; wb(1, 5'h04, 8'ha0); settle;
        wb(1, 5'h0c, 0); wb(0, 5'h04, 0); settle;
        `CHK("tmr link", 1, tmr);
        `CHK("pin two", 1, p2);
        `CHK("override two", 1, ov2);
        `CHK("override one", 0, ov1);
        raw2 <= 0; settle;
        wb(0, 5'h0c, 0); `CHK("flag two", 8'h40, q[7:0]);
        ce <= 0; raw2 <= 1; settle; `CHK("frozen", 0, tmr);
        ce <= 1; settle; `CHK("thawed", 1, tmr);
        done("comparator two");
        @(posedge CLOCK_I); RST_N_I <= 0;
        repeat (2) @(posedge CLOCK_I); RST_N_I <= 1;
        wb(0, 5'h00, 0); `CHK("ctrl1 reset", 0, q[7:0]);
        `CHK("tmr reset", 0, tmr);
        `CHK("irq reset", 0, irq);
        done("reset");
        finish_test;
    end
endmodule
`default_nettype wire
